//--- verilog/dsm_top.sv
// dual encoder speed supervision and zone set selection
`timescale 1ns/10ps
`include "dsm_params.svh"
module dsm_top #(
  parameter int MS_CYCLES = `DSM_CLK_KHZ,
  parameter int SAMPLE_MS = `DSM_SAMPLE_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] enc_a,
  input wire logic [1:0] enc_b,
  input wire logic [7:0] area_sel,
  input wire logic [1:0] area_clear,
  input wire logic warn_clear,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [3:0] safety_output_pair,
  output logic std_out,
  output logic fault_out
);
  // ==========================================================
  // configuration registers
  logic [5:0] tol_q;
  logic [3:0] step_q;
  logic [6:0] zcount_q;
  logic [9:0] ppcm_q [2];
  logic [31:0] rdata_q;

  wire wr_ctrl = reg_wr && (reg_addr == `DSM_REG_CTRL);
  wire wr_scale = reg_wr && (reg_addr == `DSM_REG_SCALE);
  wire wr_stat = reg_wr && (reg_addr == `DSM_REG_STATUS);
  wire [5:0] w_tol = reg_wdata[`DSM_CTRL_TOL_LSB +: 6];
  wire [6:0] w_zone = reg_wdata[`DSM_CTRL_ZONE_LSB +: 7];
  wire [5:0] tol_d;
  wire [6:0] zcount_d;
  wire [9:0] w_p [2];
  wire [9:0] ppcm_d [2];

  assign tol_d = (w_tol > 6'(`DSM_TOL_MAX)) ?
                 6'(`DSM_TOL_MAX) : w_tol;
  assign zcount_d = (w_zone > 7'(`DSM_ZONE_MAX)) ? 7'(`DSM_ZONE_MAX) :
                    (w_zone == 7'h00) ? 7'h01 : w_zone;
  assign w_p[0] = reg_wdata[9:0];
  assign w_p[1] = reg_wdata[`DSM_SCALE_P2_LSB +: 10];

  // ==========================================================
  // per-encoder decoding and speed classification
  dsm_enc_if enc_if [2] ();
  dsm_pkg::dsm_cnt_t cnt [2];
  logic [11:0] mag [2];
  logic [31:0] sp [2];
  logic [1:0] ge_low;
  logic [1:0] ge_high;
  logic [1:0] over;
  logic sample_tick;

  for (genvar g = 0; g < 2; g++) begin : g_enc
    assign enc_if[g].ph_a = enc_a[g];
    assign enc_if[g].ph_b = enc_b[g];
    assign enc_if[g].sample = sample_tick;
    assign cnt[g] = enc_if[g].cnt;
    assign ppcm_d[g] = (w_p[g] < 10'(`DSM_PPCM_MIN)) ? 10'(`DSM_PPCM_MIN) :
                       (w_p[g] > 10'(`DSM_PPCM_MAX)) ?
                       10'(`DSM_PPCM_MAX) : w_p[g];
    assign mag[g] = cnt[g][11] ? 12'(-cnt[g]) : 12'(cnt[g]);
    // speed = count * samples per second / ppcm, compared by cross product
    assign ge_low[g] = ({20'h0, mag[g]} * 32'(`DSM_SPS)) >=
                       (32'(`DSM_LOW_CMS) * {22'h0, ppcm_q[g]});
    assign ge_high[g] = ({20'h0, mag[g]} * 32'(`DSM_SPS)) >=
                        (32'(`DSM_HIGH_CMS) * {22'h0, ppcm_q[g]});
    // more than 100 kHz is beyond the measurable speed
    assign over[g] = mag[g] > 12'(`DSM_MAX_PULSES);
    dsm_enc u_enc (
      .clk(clk),
      .rst_n(rst_n),
      .bus(enc_if[g])
    );
  end

  // common denominator ppcm0 * ppcm1 makes the two speeds comparable
  assign sp[0] = {20'h0, mag[0]} * {22'h0, ppcm_q[1]};
  assign sp[1] = {20'h0, mag[1]} * {22'h0, ppcm_q[0]};

  // ==========================================================
  // mismatch, reference band and direction
  wire ref_is1 = sp[1] > sp[0];
  wire [31:0] fast = ref_is1 ? sp[1] : sp[0];
  wire [31:0] slow = ref_is1 ? sp[0] : sp[1];
  wire ref_low = ref_is1 ? ge_low[1] : ge_low[0];
  wire ref_high = ref_is1 ? ge_high[1] : ge_high[0];
  // 100*(fast-slow)/slow > tol, rewritten without a divider
  wire exceed = (32'd100 * fast) >
                ((32'd100 + {26'h0, tol_q}) * slow);
  wire dir_opp = (cnt[0] != 12'sh000) && (cnt[1] != 12'sh000) &&
                 (cnt[0][11] != cnt[1][11]);
  wire [12:0] grace_lim = ref_high ? 13'(`DSM_GRACE_HI_N) :
                          13'(`DSM_GRACE_MID_N);

  // ==========================================================
  // time base
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_q;
  logic [$clog2(SAMPLE_MS+1)-1:0] smp_cnt_q;
  wire ms_tick = (ms_cnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign sample_tick = ms_tick &&
    (smp_cnt_q == ($clog2(SAMPLE_MS+1))'(SAMPLE_MS - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
      smp_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      if (sample_tick) begin
        smp_cnt_q <= '0;
      end else if (ms_tick) begin
        smp_cnt_q <= smp_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // grace and direction timers, evaluated per sample
  logic [12:0] grace_q;
  logic [12:0] grace_d;
  logic [5:0] dir_q;
  logic [5:0] dir_d;
  wire grace_run = exceed && ref_low;
  wire spd_hit = sample_tick && grace_run &&
                 (grace_q >= grace_lim);
  wire dir_run = dir_opp && ref_low;
  wire dir_hit = sample_tick && dir_run &&
                 (dir_q >= 6'(`DSM_DIR_N));

  assign grace_d = !grace_run ? 13'h0000 :
                   (grace_q >= 13'(`DSM_GRACE_MID_N)) ? grace_q :
                   grace_q + 13'h0001;
  assign dir_d = !dir_run ? 6'h00 :
                 (dir_q >= 6'(`DSM_DIR_N)) ? dir_q : dir_q + 6'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grace_q <= 13'h0000;
      dir_q <= 6'h00;
    end else if (sample_tick) begin
      grace_q <= grace_d;
      dir_q <= dir_d;
    end
  end

  // ==========================================================
  // zone set selection with settle delay
  dsm_pkg::dsm_zs_t zs_q;
  dsm_pkg::dsm_zs_t zs_d;
  logic [7:0] sel_q;
  logic [8:0] settle_q;
  logic [6:0] zone_q;
  wire multi = zcount_q >= 7'h02;
  wire sel_chg = area_sel != sel_q;
  wire [8:0] settle_lim = 9'(`DSM_SETTLE_MS) *
                          ({5'h00, step_q} + 9'h001);
  wire settle_done = (zs_q == dsm_pkg::DSM_ZS_WAIT) && !sel_chg &&
                     (settle_q >= settle_lim);
  // even parity codes differ pairwise in two bits at least
  wire sel_par_ok = ~^area_sel;
  wire [6:0] sel_idx = area_sel[7:1];
  wire sel_valid = sel_par_ok && (sel_idx < zcount_q);
  wire zone_bad = settle_done && !sel_valid;

  always_comb begin
    zs_d = zs_q;
    unique case (zs_q)
      dsm_pkg::DSM_ZS_IDLE: begin
        if (multi && sel_chg) begin
          zs_d = dsm_pkg::DSM_ZS_WAIT;
        end
      end
      dsm_pkg::DSM_ZS_WAIT: begin
        if (!multi || settle_done) begin
          zs_d = dsm_pkg::DSM_ZS_IDLE;
        end
      end
      default: begin
        zs_d = dsm_pkg::DSM_ZS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zs_q <= dsm_pkg::DSM_ZS_IDLE;
      sel_q <= 8'h00;
      settle_q <= 9'h000;
      zone_q <= 7'h00;
    end else begin
      zs_q <= zs_d;
      sel_q <= area_sel;
      if (sel_chg) begin
        settle_q <= 9'h000;
      end else if (ms_tick && (settle_q != 9'h1ff)) begin
        settle_q <= settle_q + 9'h001;
      end
      if (!multi) begin
        zone_q <= 7'h00;
      end else if (settle_done && sel_valid) begin
        zone_q <= sel_idx;
      end
    end
  end

  // ==========================================================
  // latched faults, cleared by writing ones; a new fault wins
  logic [3:0] flt_q;
  wire [3:0] flt_set = {sample_tick && |over, zone_bad, dir_hit, spd_hit};
  wire [3:0] flt_clr = wr_stat ? reg_wdata[`DSM_ST_FLT_LSB +: 4] : 4'h0;
  wire run_ok = ~|flt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_q <= 4'h0;
    end else begin
      flt_q <= flt_set | (flt_q & ~flt_clr);
    end
  end

  // ==========================================================
  // outputs: one pair per safety area, one standard output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safety_output_pair <= 4'h0;
      std_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      safety_output_pair <= {{2{area_clear[1] & run_ok}},
                             {2{area_clear[0] & run_ok}}};
      std_out <= warn_clear & run_ok;
      fault_out <= !run_ok;
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tol_q <= 6'(`DSM_TOL_RST);
      step_q <= 4'h0;
      zcount_q <= 7'(`DSM_ZONE_RST);
      ppcm_q[0] <= 10'(`DSM_PPCM_RST);
      ppcm_q[1] <= 10'(`DSM_PPCM_RST);
    end else begin
      if (wr_ctrl) begin
        tol_q <= tol_d;
        step_q <= reg_wdata[`DSM_CTRL_STEP_LSB +: 4];
        zcount_q <= zcount_d;
      end
      if (wr_scale) begin
        ppcm_q[0] <= ppcm_d[0];
        ppcm_q[1] <= ppcm_d[1];
      end
    end
  end

  // ==========================================================
  // register reads, data valid in the cycle after the strobe
  wire [31:0] rd_ctrl = {9'h000, zcount_q, 4'h0, step_q, 2'h0, tol_q};
  wire [31:0] rd_scale = {6'h00, ppcm_q[1], 6'h00, ppcm_q[0]};
  wire [31:0] rd_stat = {12'h000, flt_q, 7'h00,
                         zs_q == dsm_pkg::DSM_ZS_WAIT, 1'b0, zone_q};
  wire [31:0] rd_speed = {4'h0, cnt[1], 4'h0, cnt[0]};
  wire [31:0] rd_mux = (reg_addr == `DSM_REG_CTRL) ? rd_ctrl :
                       (reg_addr == `DSM_REG_SCALE) ? rd_scale :
                       (reg_addr == `DSM_REG_STATUS) ? rd_stat :
                       (reg_addr == `DSM_REG_SPEED) ? rd_speed : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // checks
  property p_trip_off;
    @(posedge clk) disable iff (!rst_n)
      spd_hit |=> ##1 safety_output_pair == 4'h0 && fault_out;
  endproperty
  a_trip_off: assert property (p_trip_off)
    else $error("outputs stayed on after speed mismatch trip");

  property p_low_band;
    @(posedge clk) disable iff (!rst_n)
      sample_tick && !ref_low |=> grace_q == 13'h0000 && !flt_set[0];
  endproperty
  a_low_band: assert property (p_low_band)
    else $error("grace timer ran below low speed band");

  property p_mid_band;
    @(posedge clk) disable iff (!rst_n)
      spd_hit && !ref_high |-> grace_q == 13'(`DSM_GRACE_MID_N);
  endproperty
  a_mid_band: assert property (p_mid_band)
    else $error("mid band trip at wrong grace count");

  property p_high_band;
    @(posedge clk) disable iff (!rst_n)
      sample_tick && grace_run && ref_high &&
      grace_q == 13'(`DSM_GRACE_HI_N) |=> flt_q[0];
  endproperty
  a_high_band: assert property (p_high_band)
    else $error("high band grace time not enforced");

  property p_dir;
    @(posedge clk) disable iff (!rst_n)
      sample_tick && dir_run && dir_q == 6'(`DSM_DIR_N) |=> flt_q[1];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction disagreement not enforced");

  property p_accept;
    @(posedge clk) disable iff (!rst_n)
      settle_done && sel_valid && multi |=> zone_q == $past(sel_idx);
  endproperty
  a_accept: assert property (p_accept)
    else $error("settled selection not activated");

  property p_invalid;
    @(posedge clk) disable iff (!rst_n)
      zone_bad |=> flt_q[2] ##1 fault_out;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid selection did not fault");

  property p_single;
    @(posedge clk) disable iff (!rst_n)
      !multi |=> zone_q == 7'h00;
  endproperty
  a_single: assert property (p_single)
    else $error("zone changed with a single zone set");

  property p_ranges;
    @(posedge clk) disable iff (!rst_n)
      tol_q <= 6'(`DSM_TOL_MAX) && zcount_q <= 7'(`DSM_ZONE_MAX) &&
      zcount_q != 7'h00 &&
      ppcm_q[0] >= 10'(`DSM_PPCM_MIN) && ppcm_q[0] <= 10'(`DSM_PPCM_MAX) &&
      ppcm_q[1] >= 10'(`DSM_PPCM_MIN) && ppcm_q[1] <= 10'(`DSM_PPCM_MAX);
  endproperty
  a_ranges: assert property (p_ranges)
    else $error("configuration outside its range");
endmodule

//--- common/dsm_params.svh
// constants and field layout of the dual encoder speed monitor
`ifndef DSM_PARAMS_SVH
`define DSM_PARAMS_SVH

// ==========================================================
// timing
`define DSM_CLK_KHZ 25000
`define DSM_FMAX_HZ 100000
`define DSM_SAMPLE_MS 10
`define DSM_SPS (1000 / `DSM_SAMPLE_MS)
`define DSM_MAX_PULSES (`DSM_FMAX_HZ / `DSM_SPS)
`define DSM_LOW_CMS 10
`define DSM_HIGH_CMS 30
`define DSM_GRACE_MID_S 60
`define DSM_GRACE_HI_S 20
`define DSM_DIR_DS 4
`define DSM_GRACE_MID_N (`DSM_GRACE_MID_S * `DSM_SPS)
`define DSM_GRACE_HI_N (`DSM_GRACE_HI_S * `DSM_SPS)
`define DSM_DIR_N (`DSM_DIR_DS * `DSM_SPS / 10)
`define DSM_SETTLE_MS 30
// ==========================================================
// limits and reset values
`define DSM_TOL_MAX 45
`define DSM_TOL_RST 25
`define DSM_PPCM_MIN 50
`define DSM_PPCM_MAX 1000
`define DSM_PPCM_RST 50
`define DSM_ZONE_MAX 70
`define DSM_ZONE_RST 1
// ==========================================================
// register offsets
`define DSM_REG_CTRL 8'h00
`define DSM_REG_SCALE 8'h04
`define DSM_REG_STATUS 8'h08
`define DSM_REG_SPEED 8'h0c
// ==========================================================
// field positions
`define DSM_CTRL_TOL_LSB 0
`define DSM_CTRL_STEP_LSB 8
`define DSM_CTRL_ZONE_LSB 16
`define DSM_SCALE_P2_LSB 16
`define DSM_ST_BUSY_BIT 8
`define DSM_ST_FLT_LSB 16
`define DSM_SPEED_C2_LSB 16
`endif

//--- common/dsm_pkg.sv
// types of the dual encoder speed monitor
package dsm_pkg;
  typedef logic signed [11:0] dsm_cnt_t;
  typedef enum logic [1:0] {
    DSM_ZS_IDLE = 2'b01,
    DSM_ZS_WAIT = 2'b10
  } dsm_zs_t;
endpackage

//--- common/dsm_enc_if.sv
// link between the core and one quadrature decoder
`timescale 1ns/10ps
interface dsm_enc_if;
  logic ph_a;
  logic ph_b;
  logic sample;
  dsm_pkg::dsm_cnt_t cnt;
  modport enc(input ph_a, input ph_b, input sample, output cnt);
  modport core(output ph_a, output ph_b, output sample, input cnt);
endinterface

//--- verilog/dsm_enc.sv
// quadrature decoder with per-interval signed pulse count
`timescale 1ns/10ps
module dsm_enc (
  input wire logic clk,
  input wire logic rst_n,
  dsm_enc_if.enc bus
);
  logic a_q;
  dsm_pkg::dsm_cnt_t acc_q;
  dsm_pkg::dsm_cnt_t acc_d;
  dsm_pkg::dsm_cnt_t cnt_q;
  dsm_pkg::dsm_cnt_t step;
  wire rise = bus.ph_a & ~a_q;
  wire at_top = (acc_q == 12'sh7ff);
  wire at_bot = (acc_q == -12'sh7ff);

  // b low at a rise means forward
  assign step = (rise && !bus.ph_b && !at_top) ? 12'sh001 :
                (rise && bus.ph_b && !at_bot) ? -12'sh001 : 12'sh000;
  // a pulse in the sample cycle goes to the latched count only
  assign acc_d = bus.sample ? 12'sh000 : acc_q + step;
  assign bus.cnt = cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      acc_q <= 12'sh000;
      cnt_q <= 12'sh000;
    end else begin
      a_q <= bus.ph_a;
      acc_q <= acc_d;
      if (bus.sample) begin
        cnt_q <= acc_q + step;
      end
    end
  end

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      bus.sample |=> acc_q == 12'sh000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("count did not restart after sample");
endmodule

//--- dv/dsm_enc_model.sv
// quadrature incremental encoder model for one wheel
`timescale 1ns/10ps
module dsm_enc_model (
  input wire logic clk,
  input wire logic [7:0] quarter,
  input wire logic fwd,
  output logic ph_a,
  output logic ph_b
);
  logic [1:0] phase_q = 2'h0;
  logic [7:0] tick_q = 8'h00;

  // ==========================================================
  // phase stepping
  // one quarter turn every quarter cycles, zero stands still;
  // lines hold their level while the wheel stands
  always @(posedge clk) begin
    if (quarter != 8'h00) begin
      if (tick_q + 8'h01 >= quarter) begin
        tick_q <= 8'h00;
        phase_q <= fwd ? phase_q + 2'h1 : phase_q - 2'h1;
      end else begin
        tick_q <= tick_q + 8'h01;
      end
    end
  end

  // two phases a quarter period apart, order gives direction
  // pulse rate stays far below what one sample can count
  assign ph_a = phase_q[0] ^ phase_q[1];
  assign ph_b = phase_q[1];
endmodule

//--- dv/dual_encoder_speed_monitor_bench.sv
// self-checking bench of the dual encoder speed monitor
`timescale 1ns/10ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module dual_encoder_speed_monitor_bench;
  localparam int MSC = 6;
  localparam int SPC = MSC * 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire [1:0] enc_a;
  wire [1:0] enc_b;
  logic [7:0] area_sel = 8'h00;
  logic [1:0] area_clear = 2'h0;
  logic warn_clear = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] safety_output_pair;
  logic std_out;
  logic fault_out;
  logic [7:0] q0 = 8'h00;
  logic [7:0] q1 = 8'h00;
  logic f0 = 1'b1;
  logic f1 = 1'b1;
  logic [31:0] rdv;
  int err_total = 0;
  int comparisons = 0;

  dsm_enc_model enc0_m (.clk(clk), .quarter(q0), .fwd(f0),
    .ph_a(enc_a[0]), .ph_b(enc_b[0]));
  dsm_enc_model enc1_m (.clk(clk), .quarter(q1), .fwd(f1),
    .ph_a(enc_a[1]), .ph_b(enc_b[1]));

  dsm_top #(.MS_CYCLES(MSC), .SAMPLE_MS(10)) uut (
    .clk(clk),
    .rst_n(rst_n),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .area_sel(area_sel),
    .area_clear(area_clear),
    .warn_clear(warn_clear),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .safety_output_pair(safety_output_pair),
    .std_out(std_out),
    .fault_out(fault_out)
  );

  always #20 clk = ~clk;

  // ==========================================================
  // bus and timing tasks
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rdv = reg_rdata;
  endtask

  task automatic run_ms(input int n);
    repeat (n * MSC) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic run_smp(input int n);
    repeat (n * SPC) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    // the tests need about 128000 cycles
    repeat (135000) @(posedge clk);
    err_total++;
    stop_test;
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h00);
    `CHK(rdv, 32'h0001_0019)
    rd_reg(8'h04);
    `CHK(rdv, 32'h0032_0032)
    rd_reg(8'h10);
    `CHK(rdv, 32'h0000_0000)
    wr_reg(8'h00, 32'h007f_003f);
    rd_reg(8'h00);
    `CHK(rdv, 32'h0046_002d)
    wr_reg(8'h04, 32'h03f0_000a);
    rd_reg(8'h04);
    `CHK(rdv, 32'h03e8_0032)
    wr_reg(8'h00, 32'h0001_0019);
    wr_reg(8'h04, 32'h0032_0032);
    // outputs follow the area inputs while no fault stands
    area_clear <= 2'b01;
    warn_clear <= 1'b1;
    run_ms(1);
    `CHK(safety_output_pair, 4'h3)
    `CHK(std_out, 1'b1)
    @(posedge clk);
    area_clear <= 2'b11;
    // 15 pulses per sample on each wheel, then one reversed
    q0 <= 8'h01;
    q1 <= 8'h01;
    run_smp(3);
    rd_reg(8'h0c);
    `CHK(rdv, 32'h000f_000f)
    @(posedge clk);
    f1 <= 1'b0;
    run_smp(3);
    rd_reg(8'h0c);
    `CHK(rdv, 32'h0ff1_000f)
    // opposite directions at crawling speed never trip
    @(posedge clk);
    q0 <= 8'h0a;
    q1 <= 8'h0a;
    run_smp(45);
    `CHK(fault_out, 1'b0)
    // opposite directions at 15 cm/s trip after 40 samples
    @(posedge clk);
    q0 <= 8'h02;
    q1 <= 8'h02;
    run_smp(35);
    `CHK(fault_out, 1'b0)
    run_smp(10);
    rd_reg(8'h08);
    `CHK(rdv[19:16], 4'h2)
    `CHK(safety_output_pair, 4'h0)
    @(posedge clk);
    f1 <= 1'b1;
    run_smp(3);
    wr_reg(8'h08, 32'h000f_0000);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0000)
    `CHK(safety_output_pair, 4'hf)
    // single zone set: selection changes start no settle
    @(posedge clk);
    area_sel <= 8'h05;
    run_ms(40);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0000)
    @(posedge clk);
    area_sel <= 8'h00;
    wr_reg(8'h00, 32'h0004_0019);
    area_sel <= 8'h05;
    run_ms(20);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0100)
    run_ms(20);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0002)
    // one extra step doubles the settle time; odd parity is invalid
    wr_reg(8'h00, 32'h0004_0119);
    area_sel <= 8'h04;
    run_ms(45);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0102)
    run_ms(25);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0004_0002)
    `CHK(fault_out, 1'b1)
    // another valid code selects its own zone set
    @(posedge clk);
    area_sel <= 8'h03;
    run_ms(70);
    wr_reg(8'h08, 32'h000f_0000);
    rd_reg(8'h08);
    `CHK(rdv, 32'h0000_0001)
    // 30 cm/s against 15 cm/s: the faster picks the 2000-sample band
    @(posedge clk);
    q0 <= 8'h01;
    q1 <= 8'h02;
    run_smp(1990);
    `CHK(fault_out, 1'b0)
    run_smp(20);
    rd_reg(8'h08);
    `CHK(rdv[19:16], 4'h1)
    `CHK(safety_output_pair, 4'h0)
    `CHK(std_out, 1'b0)
    stop_test;
  end
endmodule
